/* File: mrsc_ctrl.sv */
/*
 Speed selection and management control of a multi-rate Ethernet PHY.
 Assumes a word-indexed register port synchronous to i_core_clk, and an
 external reset controller that asserts i_rst_b after each mode change.
*/
`timescale 1ns/1ns
`default_nettype none
// Operation
// - 1G family: 1.25G lane, GMII16 62.5MHz
// - 2.5G: 3.125G lane, GMII16 156.25MHz
// - SGMII replicates 100x at 10M, 10x 100M
// - 10G: 10.3125G lane, XGMII64 156.25MHz
// - USXGMII replicates 1000/100/10/4/2/1 by speed
// - USXGMII: 10.3125G lane, XGMII32 312.5MHz
// - SGMII/USXGMII speed changes via own registers
// - Registers at 0x00-0x1F, 0x400-0x41F, 0x461
// - Write-one-to-act bits self-clear after action
// - Control bit 15 soft reset, registers kept
// - Control bit 14 enables serial loopback
// - Auto-negotiation enable only effective at 1G
// - Bit 9 restarts negotiation, clears on start
module mrsc_ctrl
	import mrsc_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic [1:0] i_xcvr_mode,
	input wire logic [1:0] i_sgmii_an_speed,
	input wire logic [2:0] i_usx_an_speed,
	input wire logic [10:0] i_csr_addr,
	input wire logic i_csr_read,
	input wire logic i_csr_write,
	input wire logic [31:0] i_csr_wdata,
	output logic [31:0] o_csr_rdata,
	output logic o_csr_rvalid,
	output logic [1:0] o_lane_rate,
	output logic [1:0] o_mac_if,
	output logic o_pcs_xgmii,
	output logic [9:0] o_rep_factor,
	output logic o_unit_strobe,
	output logic o_serial_loopback,
	output logic o_soft_reset,
	output logic o_an_enable,
	output logic o_an_restart,
	output logic o_datapath_en
);
	// ====================================================================
	// State
	typedef struct packed {
		logic ctl_sr;
		logic ctl_lb;
		logic ctl_an;
		logic ctl_rs;
		logic ifm_sgmii;
		logic ifm_usean;
		logic [1:0] ifm_spd;
		logic usx_ena;
		logic usx_anena;
		logic [2:0] usx_spd;
		logic usx_rs;
		logic slb;
		logic [3:0] cnt;
		mrsc_mode_type mode;
		mrsc_dp_type dp;
		logic [31:0] rdata;
		logic rvalid;
		logic an_restart;
		logic soft_rst;
		mrsc_lane_type lane;
		mrsc_macif_type macif;
		logic [9:0] rep;
		logic an_en;
		logic loopback;
		logic dp_en;
	} mrsc_state_type;
	mrsc_state_type s_q;
	mrsc_state_type s_d;

	function automatic logic [9:0] rep_of(input logic [2:0] spd);
		case (spd)
			MRSC_SPD_10M: rep_of = MRSC_REP_1000;
			MRSC_SPD_100M: rep_of = MRSC_REP_100;
			MRSC_SPD_1G: rep_of = MRSC_REP_10;
			MRSC_SPD_2G5: rep_of = MRSC_REP_4;
			MRSC_SPD_5G: rep_of = MRSC_REP_2;
			default: rep_of = MRSC_REP_1;
		endcase
	endfunction

	logic wr_ctrl;
	logic [2:0] usx_speed;
	logic [1:0] sgmii_speed;
	assign wr_ctrl = i_csr_write && (i_csr_addr == MRSC_CTRL_ADDR);
	assign usx_speed = s_q.usx_anena ? i_usx_an_speed : s_q.usx_spd;
	assign sgmii_speed = s_q.ifm_usean ? i_sgmii_an_speed : s_q.ifm_spd;

	always_comb
	begin
		s_d = s_q;
		s_d.an_restart = 1'h0;
		s_d.rvalid = i_csr_read;
		// ================================================================
		// Self-clearing restart: the pulse marks the start
		if (s_q.ctl_rs || s_q.usx_rs)
		begin
			s_d.an_restart = 1'h1;
			s_d.ctl_rs = 1'h0;
			s_d.usx_rs = 1'h0;
		end
		// ================================================================
		// Datapath sequencing
		case (s_q.dp)
			MRSC_DP_IDLE:
			begin
				s_d.mode = mrsc_mode_type'(i_xcvr_mode);
				s_d.dp = MRSC_DP_RUN;
			end
			MRSC_DP_RUN:
			begin
				// Mode switched outside: wait for the reset that follows
				if (i_xcvr_mode != s_q.mode)
					s_d.dp = MRSC_DP_HOLD;
				else if (s_q.ctl_sr)
				begin
					s_d.dp = MRSC_DP_SRST;
					s_d.cnt = MRSC_SOFT_RST_CYC - 4'h1;
				end
			end
			MRSC_DP_SRST:
			begin
				if (s_q.cnt == 4'h0)
				begin
					s_d.ctl_sr = 1'h0;
					s_d.dp = MRSC_DP_RUN;
				end
				else
					s_d.cnt = s_q.cnt - 4'h1;
			end
			MRSC_DP_HOLD: s_d.dp = MRSC_DP_HOLD;
			default: s_d.dp = MRSC_DP_IDLE;
		endcase
		// ================================================================
		// Register writes; a set lands after the clears so it wins
		if (wr_ctrl)
		begin
			s_d.ctl_lb = i_csr_wdata[MRSC_CTRL_LB_BIT];
			s_d.ctl_an = i_csr_wdata[MRSC_CTRL_AN_BIT];
			if (i_csr_wdata[MRSC_CTRL_RST_BIT])
				s_d.ctl_sr = 1'h1;
			if (i_csr_wdata[MRSC_CTRL_RSAN_BIT])
				s_d.ctl_rs = 1'h1;
		end
		if (i_csr_write && (i_csr_addr == MRSC_IFMODE_ADDR))
		begin
			s_d.ifm_sgmii = i_csr_wdata[MRSC_IFM_SGMII_BIT];
			s_d.ifm_usean = i_csr_wdata[MRSC_IFM_USEAN_BIT];
			s_d.ifm_spd = i_csr_wdata[MRSC_IFM_SPD_LSB +: 2];
		end
		if (i_csr_write && (i_csr_addr == MRSC_USXCTL_ADDR))
		begin
			s_d.usx_ena = i_csr_wdata[MRSC_USX_ENA_BIT];
			s_d.usx_anena = i_csr_wdata[MRSC_USX_ANENA_BIT];
			s_d.usx_spd = i_csr_wdata[MRSC_USX_SPD_LSB +: 3];
			if (i_csr_wdata[MRSC_USX_RSAN_BIT])
				s_d.usx_rs = 1'h1;
		end
		if (i_csr_write && (i_csr_addr == MRSC_SLB_ADDR))
			s_d.slb = i_csr_wdata[MRSC_SLB_ENA_BIT];
		// ================================================================
		// Register reads, reserved and unmapped read as zero
		case (i_csr_addr)
			MRSC_CTRL_ADDR: s_d.rdata = {16'h0000, s_q.ctl_sr, s_q.ctl_lb, 1'h0,
				s_q.ctl_an, 2'h0, s_q.ctl_rs, 9'h000};
			MRSC_IFMODE_ADDR: s_d.rdata = {28'h0000000, s_q.ifm_spd,
				s_q.ifm_usean, s_q.ifm_sgmii};
			MRSC_USXCTL_ADDR: s_d.rdata = {22'h000000, s_q.usx_rs, 4'h0,
				s_q.usx_spd, s_q.usx_anena, s_q.usx_ena};
			MRSC_SLB_ADDR: s_d.rdata = {31'h00000000, s_q.slb};
			default: s_d.rdata = 32'h00000000;
		endcase
		if (!i_csr_read)
			s_d.rdata = 32'h00000000;
		// ================================================================
		// Speed mapping
		case (s_q.mode)
			MRSC_MODE_10G:
			begin
				s_d.lane = MRSC_LANE_10G3125;
				if (s_q.usx_ena)
				begin
					s_d.macif = MRSC_MAC_XGMII32_312M5;
					s_d.rep = rep_of(usx_speed);
				end
				else
				begin
					s_d.macif = MRSC_MAC_XGMII64_156M25;
					s_d.rep = MRSC_REP_1;
				end
			end
			MRSC_MODE_2G5:
			begin
				s_d.lane = MRSC_LANE_3G125;
				s_d.macif = MRSC_MAC_GMII16_156M25;
				s_d.rep = MRSC_REP_1;
			end
			default:
			begin
				s_d.lane = MRSC_LANE_1G25;
				s_d.macif = MRSC_MAC_GMII16_62M5;
				// SGMII repeats the USXGMII count for one code up
				s_d.rep = s_q.ifm_sgmii ? rep_of({1'h0, sgmii_speed} + 3'h1) : MRSC_REP_1;
			end
		endcase
		s_d.an_en = s_q.ctl_an && (s_q.mode == MRSC_MODE_1G) &&
			(!s_q.ifm_sgmii || sgmii_speed == 2'h2);
		s_d.loopback = s_d.ctl_lb || s_d.slb;
		s_d.soft_rst = (s_d.dp == MRSC_DP_SRST);
		s_d.dp_en = (s_d.dp == MRSC_DP_RUN);
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			s_q <= '0;
			s_q.usx_anena <= MRSC_USX_ANENA_RST;
			s_q.usx_spd <= MRSC_USX_SPD_RST;
			s_q.ifm_spd <= MRSC_IFM_SPD_RST;
			s_q.rep <= MRSC_REP_1;
		end
		else
			s_q <= s_d;
	end

	mrsc_rep u_rep (
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.i_enable(s_q.dp_en),
		.i_factor(s_q.rep),
		.o_unit_strobe(o_unit_strobe)
	);

	assign o_csr_rdata = s_q.rdata;
	assign o_csr_rvalid = s_q.rvalid;
	assign o_lane_rate = s_q.lane;
	assign o_mac_if = s_q.macif;
	assign o_pcs_xgmii = s_q.macif[1];
	assign o_rep_factor = s_q.rep;
	assign o_serial_loopback = s_q.loopback;
	assign o_soft_reset = s_q.soft_rst;
	assign o_an_enable = s_q.an_en;
	assign o_an_restart = s_q.an_restart;
	assign o_datapath_en = s_q.dp_en;

	// ====================================================================
	// Checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);

	sequence sr_window;
		##9 o_soft_reset ##1 !o_soft_reset;
	endsequence
	sequence rs_taken;
		o_an_restart && !s_q.ctl_rs;
	endsequence

	soft_rst_len_a: assert property ($rose(o_soft_reset) |-> sr_window)
		else $error("soft reset length wrong");
	soft_rst_keep_a: assert property (o_soft_reset && !$past(i_csr_write)
		|-> $stable(o_serial_loopback))
		else $error("register changed during soft reset");
	soft_rst_clr_a: assert property ($fell(o_soft_reset) && !$past(i_csr_write)
		|-> !s_q.ctl_sr)
		else $error("reset bit not cleared");
	restart_a: assert property (wr_ctrl && i_csr_wdata[9] |-> ##1 s_q.ctl_rs ##1 rs_taken)
		else $error("restart bit not handled");
	loopback_on_a: assert property (wr_ctrl && i_csr_wdata[14] |=> o_serial_loopback)
		else $error("loopback not enabled");
	usx_rep_a: assert property (s_q.mode == MRSC_MODE_10G && s_q.usx_ena && !s_q.usx_anena
		&& s_q.usx_spd == 3'h0 |=> o_rep_factor == 10'h3e8)
		else $error("usx replication wrong");
	sgmii_rep_a: assert property (s_q.mode == MRSC_MODE_1G && s_q.ifm_sgmii && !s_q.ifm_usean
		&& s_q.ifm_spd == 2'h1 |=> o_rep_factor == 10'h00a)
		else $error("sgmii replication wrong");
	usx_lane_a: assert property (o_mac_if == MRSC_MAC_XGMII32_312M5
		|-> o_lane_rate == MRSC_LANE_10G3125 && o_pcs_xgmii)
		else $error("usx lane wrong");
	an_gate_a: assert property (o_an_enable |-> o_mac_if == MRSC_MAC_GMII16_62M5)
		else $error("negotiation outside 1G");
	mode_hold_a: assert property (o_datapath_en && i_xcvr_mode != s_q.mode
		|=> !o_datapath_en [*2])
		else $error("datapath active after mode change");
endmodule // mrsc_ctrl
`default_nettype wire

/* File: mrsc_pkg.sv */
/*
 Constants and types for the multi-rate PHY speed and management control block.
 Assumes a word-indexed management address and a 2-bit transceiver-mode select.
*/
`default_nettype none
package mrsc_pkg;
	// ====================================================================
	// Register word indices
	localparam logic [10:0] MRSC_CTRL_ADDR = 11'h000;
	localparam logic [10:0] MRSC_IFMODE_ADDR = 11'h014;
	localparam logic [10:0] MRSC_USXCTL_ADDR = 11'h400;
	localparam logic [10:0] MRSC_SLB_ADDR = 11'h461;
	// ====================================================================
	// Field positions
	localparam int MRSC_CTRL_RST_BIT = 15;
	localparam int MRSC_CTRL_LB_BIT = 14;
	localparam int MRSC_CTRL_AN_BIT = 12;
	localparam int MRSC_CTRL_RSAN_BIT = 9;
	localparam int MRSC_IFM_SGMII_BIT = 0;
	localparam int MRSC_IFM_USEAN_BIT = 1;
	localparam int MRSC_IFM_SPD_LSB = 2;
	localparam int MRSC_USX_ENA_BIT = 0;
	localparam int MRSC_USX_ANENA_BIT = 1;
	localparam int MRSC_USX_SPD_LSB = 2;
	localparam int MRSC_USX_RSAN_BIT = 9;
	localparam int MRSC_SLB_ENA_BIT = 0;
	// ====================================================================
	// Reset values
	localparam logic MRSC_USX_ANENA_RST = 1'h1;
	localparam logic MRSC_BIT_RST = 1'h0;
	localparam logic [2:0] MRSC_USX_SPD_RST = 3'h0;
	localparam logic [1:0] MRSC_IFM_SPD_RST = 2'h0;
	// ====================================================================
	// Timing
	localparam int MRSC_CLK_PERIOD_NS = 100;
	localparam int MRSC_SOFT_RST_NS = 1000;
	localparam logic [3:0] MRSC_SOFT_RST_CYC =
		4'((MRSC_SOFT_RST_NS + MRSC_CLK_PERIOD_NS - 1) / MRSC_CLK_PERIOD_NS);
	// ====================================================================
	// Replication factors
	localparam logic [9:0] MRSC_REP_1000 = 10'h3e8;
	localparam logic [9:0] MRSC_REP_100 = 10'h064;
	localparam logic [9:0] MRSC_REP_10 = 10'h00a;
	localparam logic [9:0] MRSC_REP_4 = 10'h004;
	localparam logic [9:0] MRSC_REP_2 = 10'h002;
	localparam logic [9:0] MRSC_REP_1 = 10'h001;
	// ====================================================================
	// Types
	typedef enum logic [1:0] {
		MRSC_MODE_1G = 2'h0,
		MRSC_MODE_2G5 = 2'h1,
		MRSC_MODE_10G = 2'h2
	} mrsc_mode_type;
	typedef enum logic [2:0] {
		MRSC_SPD_10M = 3'h0,
		MRSC_SPD_100M = 3'h1,
		MRSC_SPD_1G = 3'h2,
		MRSC_SPD_10G = 3'h3,
		MRSC_SPD_2G5 = 3'h4,
		MRSC_SPD_5G = 3'h5
	} mrsc_speed_type;
	typedef enum logic [1:0] {
		MRSC_LANE_1G25 = 2'h0,
		MRSC_LANE_3G125 = 2'h1,
		MRSC_LANE_10G3125 = 2'h2
	} mrsc_lane_type;
	typedef enum logic [1:0] {
		MRSC_MAC_GMII16_62M5 = 2'h0,
		MRSC_MAC_GMII16_156M25 = 2'h1,
		MRSC_MAC_XGMII64_156M25 = 2'h2,
		MRSC_MAC_XGMII32_312M5 = 2'h3
	} mrsc_macif_type;
	typedef enum logic [1:0] {
		MRSC_DP_IDLE = 2'h0,
		MRSC_DP_RUN = 2'h1,
		MRSC_DP_SRST = 2'h2,
		MRSC_DP_HOLD = 2'h3
	} mrsc_dp_type;
endpackage
`default_nettype wire

/* File: mrsc_reconfig_model.sv */
/*
 Model of the speed reconfiguration block and the transceiver reset controller.
 Assumes one clock; a request pulse starts a full speed change from idle.
*/
`timescale 1ns/1ns
`default_nettype none
module mrsc_reconfig_model
	import mrsc_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_por_b,
	input wire logic i_req,
	input wire logic i_slow,
	input wire logic [1:0] i_req_mode,
	output logic [1:0] o_xcvr_mode,
	output logic o_rst_b,
	output logic o_busy
);
	logic [2:0] step_q;
	logic [3:0] tmr_q;
	// ====================================================================
	// Steps: 1 load settings, 2 select PLL, 3 recalibrate, 4 reset
	always_ff @(posedge i_core_clk or negedge i_por_b)
	begin
		if (!i_por_b)
		begin
			step_q <= 3'h0;
			tmr_q <= 4'h0;
			o_xcvr_mode <= 2'h0;
		end
		else if (i_req && step_q == 3'h0)
		begin
			o_xcvr_mode <= i_req_mode;
			step_q <= 3'h1;
			tmr_q <= i_slow ? 4'h8 : 4'h1;
		end
		else if (step_q != 3'h0)
		begin
			if (tmr_q != 4'h0)
				tmr_q <= tmr_q - 4'h1;
			else
			begin
				step_q <= (step_q == 3'h4) ? 3'h0 : step_q + 3'h1;
				tmr_q <= i_slow ? 4'h8 : 4'h1;
			end
		end
	end
	assign o_busy = (step_q != 3'h0);
	// Reset is the last step, so the block never runs on half-set settings
	assign o_rst_b = i_por_b && (step_q != 3'h4);
endmodule // mrsc_reconfig_model
`default_nettype wire

/* File: mrsc_rep.sv */
/*
 Data-unit replication pacer: one strobe every factor cycles.
 Assumes factor is stable while enabled; a factor of 1 strobes every cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module mrsc_rep
	import mrsc_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic i_enable,
	input wire logic [9:0] i_factor,
	output logic o_unit_strobe
);
	typedef struct packed {
		logic [9:0] cnt;
		logic stb;
	} mrsc_rep_type;
	mrsc_rep_type s_q;
	mrsc_rep_type s_d;

	always_comb
	begin
		s_d = s_q;
		s_d.stb = 1'h0;
		if (!i_enable)
		begin
			s_d.cnt = 10'h000;
		end
		else if (s_q.cnt >= i_factor - 10'h001)
		begin
			// New unit taken; the rest of the window repeats it
			s_d.cnt = 10'h000;
			s_d.stb = 1'h1;
		end
		else
		begin
			s_d.cnt = s_q.cnt + 10'h001;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign o_unit_strobe = s_q.stb;
endmodule // mrsc_rep
`default_nettype wire

/* File: tb.sv */
/*
 Self-checking testbench for the speed and management control block.
 Assumes the reconfiguration model owns the mode select and the reset.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
	import mrsc_pkg::*;
	logic clk, por_b, req, slow, rd_s, wr_s;
	logic [1:0] req_mode, xmode, sg_spd, lane, macif;
	logic [2:0] ux_spd;
	logic [10:0] addr;
	logic [31:0] wdata, rdata;
	logic rvalid, rst_b, busy, strobe, lb, srst, an_en, an_rs, dp_en, pcs_x;
	logic [9:0] rep;
	logic [9:0] sg_rep [3] = '{MRSC_REP_100, MRSC_REP_10, MRSC_REP_1};
	logic [9:0] ux_rep [6] = '{MRSC_REP_1000, MRSC_REP_100, MRSC_REP_10, MRSC_REP_1,
		MRSC_REP_4, MRSC_REP_2};
	int fails = 0;
	int compares = 0;
	int cyc = 0;
	int n_stb, n_srst, n_anr, n_off;
	// ====================================================================
	// Clock, model and design
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	mrsc_reconfig_model u_rcfg (.i_core_clk(clk), .i_por_b(por_b), .i_req(req),
		.i_slow(slow), .i_req_mode(req_mode), .o_xcvr_mode(xmode), .o_rst_b(rst_b),
		.o_busy(busy));
	mrsc_ctrl uut (.i_core_clk(clk), .i_rst_b(rst_b), .i_xcvr_mode(xmode),
		.i_sgmii_an_speed(sg_spd), .i_usx_an_speed(ux_spd), .i_csr_addr(addr),
		.i_csr_read(rd_s), .i_csr_write(wr_s), .i_csr_wdata(wdata), .o_csr_rdata(rdata),
		.o_csr_rvalid(rvalid), .o_lane_rate(lane), .o_mac_if(macif), .o_pcs_xgmii(pcs_x),
		.o_rep_factor(rep), .o_unit_strobe(strobe), .o_serial_loopback(lb),
		.o_soft_reset(srst), .o_an_enable(an_en), .o_an_restart(an_rs),
		.o_datapath_en(dp_en));
	// ====================================================================
	// Tasks
	task automatic results();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [10:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [10:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		// Read data stands only in the cycle after the read edge
		#1;
		check({31'h0, rvalid}, 32'h1);
		check(rdata, exp);
	endtask
	task automatic sample(input int n);
		n_stb = 0;
		n_srst = 0;
		n_anr = 0;
		n_off = 0;
		repeat (n)
		begin
			@(posedge clk);
			#1;
			n_stb += (strobe === 1'b1);
			n_srst += (srst === 1'b1);
			n_anr += (an_rs === 1'b1);
			n_off += (dp_en === 1'b0);
		end
	endtask
	task automatic map(input logic [1:0] l, input logic [1:0] m, input logic p,
		input logic [9:0] r);
		repeat (3) @(posedge clk);
		#1;
		check({30'h0, lane}, {30'h0, l});
		check({30'h0, macif}, {30'h0, m});
		check({31'h0, pcs_x}, {31'h0, p});
		check({22'h0, rep}, {22'h0, r});
	endtask
	task automatic swap(input logic [1:0] m, input logic s);
		@(posedge clk);
		req <= 1'b1;
		req_mode <= m;
		slow <= s;
		@(posedge clk);
		req <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		check({31'h0, dp_en}, 32'h0);
		for (int i = 0; i < 60 && busy; i++)
			@(posedge clk);
		repeat (3) @(posedge clk);
	endtask
	// ====================================================================
	// Hang guard: the sequence needs well under 2000 cycles
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			fails = fails + 1;
			results();
		end
	end
	// ====================================================================
	// Main sequence
	initial
	begin
		por_b = 1'b0;
		req = 1'b0;
		slow = 1'b0;
		req_mode = 2'h0;
		rd_s = 1'b0;
		wr_s = 1'b0;
		addr = 11'h0;
		wdata = 32'h0;
		sg_spd = 2'h1;
		ux_spd = 3'h4;
		repeat (12) @(posedge clk);
		por_b <= 1'b1;
		rd(MRSC_CTRL_ADDR, 32'h0);
		rd(MRSC_USXCTL_ADDR, 32'h2);
		rd(MRSC_SLB_ADDR, 32'h0);
		rd(11'h010, 32'h0);
		map(MRSC_LANE_1G25, MRSC_MAC_GMII16_62M5, 1'b0, MRSC_REP_1);
		for (int s = 0; s < 3; s++)
		begin
			wr(MRSC_IFMODE_ADDR, 32'(1 + 4 * s));
			map(MRSC_LANE_1G25, MRSC_MAC_GMII16_62M5, 1'b0, sg_rep[s]);
		end
		wr(MRSC_CTRL_ADDR, 32'h1000);
		map(MRSC_LANE_1G25, MRSC_MAC_GMII16_62M5, 1'b0, MRSC_REP_1);
		check({31'h0, an_en}, 32'h1);
		wr(MRSC_IFMODE_ADDR, 32'h3);
		map(MRSC_LANE_1G25, MRSC_MAC_GMII16_62M5, 1'b0, MRSC_REP_10);
		check({31'h0, an_en}, 32'h0);
		sample(100);
		check(32'(n_stb), 32'ha);
		// Negotiation is switched off before any later speed change
		wr(MRSC_CTRL_ADDR, 32'h4000);
		rd(MRSC_CTRL_ADDR, 32'h4000);
		check({31'h0, lb}, 32'h1);
		// Loopback bit carried along so the soft reset write keeps it
		wr(MRSC_CTRL_ADDR, 32'hc000);
		sample(14);
		check(32'(n_srst), 32'ha);
		check(32'(n_off), 32'ha);
		rd(MRSC_CTRL_ADDR, 32'h4000);
		wr(MRSC_CTRL_ADDR, 32'h4200);
		sample(4);
		check(32'(n_anr), 32'h1);
		rd(MRSC_CTRL_ADDR, 32'h4000);
		wr(MRSC_SLB_ADDR, 32'h1);
		wr(MRSC_CTRL_ADDR, 32'h0);
		rd(MRSC_SLB_ADDR, 32'h1);
		check({31'h0, lb}, 32'h1);
		swap(MRSC_MODE_2G5, 1'b1);
		map(MRSC_LANE_3G125, MRSC_MAC_GMII16_156M25, 1'b0, MRSC_REP_1);
		swap(MRSC_MODE_10G, 1'b0);
		map(MRSC_LANE_10G3125, MRSC_MAC_XGMII64_156M25, 1'b1, MRSC_REP_1);
		wr(MRSC_USXCTL_ADDR, 32'h3);
		map(MRSC_LANE_10G3125, MRSC_MAC_XGMII32_312M5, 1'b1, MRSC_REP_4);
		sample(40);
		check(32'(n_stb), 32'ha);
		for (int s = 0; s < 6; s++)
		begin
			wr(MRSC_USXCTL_ADDR, 32'(1 + 4 * s));
			map(MRSC_LANE_10G3125, MRSC_MAC_XGMII32_312M5, 1'b1, ux_rep[s]);
		end
		// Speed code 5 written back along with the restart bit
		wr(MRSC_USXCTL_ADDR, 32'h215);
		sample(4);
		check(32'(n_anr), 32'h1);
		rd(MRSC_USXCTL_ADDR, 32'h15);
		results();
	end
endmodule // tb
`default_nettype wire
